// file: hdl/lpsd_regs.vh
// Shared constants of the LED PWM serial driver core.
// Assumes inclusion by bare name from the design files below hdl/.
`ifndef LPSD_REGS_VH
`define LPSD_REGS_VH

// ----------------------------------------------------------------
// Channel layout
// ----------------------------------------------------------------
`define LPSD_CHANNELS 16
`define LPSD_GROUPS 4
`define LPSD_GROUP_SIZE 4
`define LPSD_GS_BITS 12
`define LPSD_DC_BITS 7
`define LPSD_GS_FRAME_BITS 192
`define LPSD_DC_FRAME_BITS 112

// ----------------------------------------------------------------
// Grayscale counter
// ----------------------------------------------------------------
`define LPSD_CNT_BITS 13
`define LPSD_CNT_RESET 13'h0000
`define LPSD_CNT_LAST 13'h1000

// ----------------------------------------------------------------
// Buffering and timing
// ----------------------------------------------------------------
`define LPSD_BUF_DEPTH 2
`define LPSD_BUF_PTR_BITS 1
`define LPSD_GROUP_DELAY 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LPSD_GS_LATCH_RESET 192'h0
`define LPSD_DC_LATCH_RESET 112'h0

`endif

// file: hdl/lpsd_serial_port.v
// Serial shift port: synchronisers, edge finders, shift register, cascade bit.
// Assumes the serial clock, data and latch pins are asynchronous to ref_clk_i
// and that the serial clock is well below a quarter of the reference rate.
`timescale 1ns/10ps
module lpsd_serial_port #(
   parameter WIDTH = 192
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire sclk_i,
   input wire sdin_i,
   input wire slat_i,
   output wire [WIDTH-1:0] shift_data_o,
   output wire sout_o,
   output wire sclk_rise_o,
   output wire latch_rise_o
);

   // ----------------------------------------------------------------
   // Synchronisers and edge history
   // ----------------------------------------------------------------
   reg sclk_m_r, sclk_s_r, sclk_d_r;
   reg sdin_m_r, sdin_s_r;
   reg slat_m_r, slat_s_r, slat_d_r;
   reg [WIDTH-1:0] shift_r;
   reg sout_r;
   reg sclk_rise_r;
   reg latch_rise_r;
   wire sclk_edge;
   wire [WIDTH-1:0] shift_nxt;

   // Two flops per pin, then one history flop on clock and latch
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         sclk_m_r <= 1'b0;
         sclk_s_r <= 1'b0;
         sclk_d_r <= 1'b0;
         sdin_m_r <= 1'b0;
         sdin_s_r <= 1'b0;
         slat_m_r <= 1'b0;
         slat_s_r <= 1'b0;
         slat_d_r <= 1'b0;
      end else begin
         sclk_m_r <= sclk_i;
         sclk_s_r <= sclk_m_r;
         sclk_d_r <= sclk_s_r;
         sdin_m_r <= sdin_i;
         sdin_s_r <= sdin_m_r;
         slat_m_r <= slat_i;
         slat_s_r <= slat_m_r;
         slat_d_r <= slat_s_r;
      end
   end

   assign sclk_edge = sclk_s_r & ~sclk_d_r;
   // New bit enters at the low end
   assign shift_nxt = {shift_r[WIDTH-2:0], sdin_s_r};

   // ----------------------------------------------------------------
   // Shift register and cascade output
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         shift_r <= {WIDTH{1'b0}};
         sout_r <= 1'b0;
         sclk_rise_r <= 1'b0;
         latch_rise_r <= 1'b0;
      end else begin
         sclk_rise_r <= sclk_edge;
         latch_rise_r <= slat_s_r & ~slat_d_r;
         if (sclk_edge) begin
            shift_r <= shift_nxt;
            sout_r <= shift_nxt[WIDTH-1];
         end
      end
   end

   assign shift_data_o = shift_r;
   assign sout_o = sout_r;
   assign sclk_rise_o = sclk_rise_r;
   assign latch_rise_o = latch_rise_r;

endmodule

// file: hdl/lpsd_pair_buf.v
// Small FIFO with valid and ready on both sides.
// Assumes one clock; a push into a full buffer is refused by in_ready_o low.
`timescale 1ns/10ps
module lpsd_pair_buf #(
   parameter WIDTH = 192,
   parameter DEPTH = 2,
   parameter PTR_BITS = 1
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire in_valid_i,
   input wire [WIDTH-1:0] in_data_i,
   output wire in_ready_o,
   output wire out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input wire out_ready_i
);

   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [PTR_BITS-1:0] wr_ptr_r, rd_ptr_r;
   reg [PTR_BITS:0] count_r;
   wire push, pop;

   assign in_ready_o = (count_r != DEPTH[PTR_BITS:0]);
   assign out_valid_o = (count_r != {(PTR_BITS+1){1'b0}});
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_r[rd_ptr_r];

   // Entry write
   always @(posedge ref_clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // Pointer and fill level update
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         wr_ptr_r <= {PTR_BITS{1'b0}};
         rd_ptr_r <= {PTR_BITS{1'b0}};
         count_r <= {(PTR_BITS+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[PTR_BITS-1:0] - 1'b1) ? {PTR_BITS{1'b0}} :
                        wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[PTR_BITS-1:0] - 1'b1) ? {PTR_BITS{1'b0}} :
                        rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

// file: hdl/lpsd_core.v
// Top of the LED PWM serial driver core: two serial ports, grayscale
// latch buffer, dot-correction latch, grayscale counter and channel gating.
// Assumes all pins are asynchronous to ref_clk_i, which runs much faster than
// either serial clock; analog sinks sit outside and read the channel outputs.
//
// Functional notes
// - Gray clock rise shifts input into LSB
// - Gray cascade pin shows shift register MSB
// - Gray clock rise counts while blank low
// - Gray latch rise queues frame; latch loads on accept
// - Dot clock rise shifts input into LSB
// - Dot cascade pin shows shift register MSB
// - Dot latch rise copies frame to latch
// - Blank high: outputs off, counter zero
// - Blank low: PWM compare drives each channel
// - Gray cascade always tied to MSB
`timescale 1ns/10ps
`include "lpsd_regs.vh"
module lpsd_core #(
   parameter CHANNELS = `LPSD_CHANNELS,
   parameter GS_BITS = `LPSD_GS_BITS,
   parameter DC_BITS = `LPSD_DC_BITS,
   parameter GROUP_SIZE = `LPSD_GROUP_SIZE,
   parameter GROUP_DELAY = `LPSD_GROUP_DELAY
) (
   input wire ref_clk_i,
   input wire rstn_i,
   input wire gray_serial_in_i,
   input wire gray_shift_clock_i,
   input wire gray_latch_strobe_i,
   output reg gray_serial_out_o,
   input wire dotcorr_serial_in_i,
   input wire dotcorr_shift_clock_i,
   input wire dotcorr_latch_strobe_i,
   output reg dotcorr_serial_out_o,
   input wire blank_i,
   input wire latch_accept_i,
   output reg gray_latch_ready_o,
   output reg [CHANNELS-1:0] channel_on_o,
   output reg [CHANNELS*GS_BITS-1:0] channel_gray_value_o,
   output reg [CHANNELS*DC_BITS-1:0] channel_current_step_o
);

   // ----------------------------------------------------------------
   // Local sizes
   // ----------------------------------------------------------------
   // Frame widths follow the channel word sizes
   localparam GS_FRAME = CHANNELS * GS_BITS;
   localparam DC_FRAME = CHANNELS * DC_BITS;
   localparam GROUPS = CHANNELS / GROUP_SIZE;
   localparam CNT_BITS = GS_BITS + 1;
   localparam [CNT_BITS-1:0] CNT_LAST = {1'b1, {GS_BITS{1'b0}}};
   localparam DLY_BITS = ((GROUPS - 1) * GROUP_DELAY) + 1;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [GS_FRAME-1:0] gray_shift_data;
   wire gray_sout;
   wire gray_clk_rise;
   wire gray_latch_rise;
   wire [DC_FRAME-1:0] dc_shift_data;
   wire dc_sout;
   wire dc_latch_rise;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [GS_FRAME-1:0] buf_out_data;
   reg blank_m_r, blank_s_r;
   reg [CNT_BITS-1:0] gray_cnt_r;
   reg [CNT_BITS-1:0] gray_cnt_nxt;
   wire [CHANNELS-1:0] compare_on;
   wire [CHANNELS-1:0] channel_on_nxt;
   reg [DLY_BITS-1:0] blank_dly_r;
   reg [CHANNELS-1:0] compare_dly_r [0:DLY_BITS-1];
   integer k;

   // ----------------------------------------------------------------
   // Grayscale serial port
   // ----------------------------------------------------------------
   lpsd_serial_port #(
      .WIDTH(GS_FRAME)
   ) u_gray_port (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .sclk_i(gray_shift_clock_i),
      .sdin_i(gray_serial_in_i),
      .slat_i(gray_latch_strobe_i),
      .shift_data_o(gray_shift_data),
      .sout_o(gray_sout),
      .sclk_rise_o(gray_clk_rise),
      .latch_rise_o(gray_latch_rise)
   );

   // ----------------------------------------------------------------
   // Dot-correction serial port
   // ----------------------------------------------------------------
   lpsd_serial_port #(
      .WIDTH(DC_FRAME)
   ) u_dc_port (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .sclk_i(dotcorr_shift_clock_i),
      .sdin_i(dotcorr_serial_in_i),
      .slat_i(dotcorr_latch_strobe_i),
      .shift_data_o(dc_shift_data),
      .sout_o(dc_sout),
      .sclk_rise_o(),
      .latch_rise_o(dc_latch_rise)
   );

   // ----------------------------------------------------------------
   // Grayscale latch buffer
   // ----------------------------------------------------------------
   // Latched frames wait here while the consumer holds off
   lpsd_pair_buf #(
      .WIDTH(GS_FRAME),
      .DEPTH(`LPSD_BUF_DEPTH),
      .PTR_BITS(`LPSD_BUF_PTR_BITS)
   ) u_gray_buf (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(gray_latch_rise),
      .in_data_i(gray_shift_data),
      .in_ready_o(buf_in_ready),
      .out_valid_o(buf_out_valid),
      .out_data_o(buf_out_data),
      .out_ready_i(latch_accept_i)
   );

   // ----------------------------------------------------------------
   // Data latches and cascade outputs
   // ----------------------------------------------------------------
   // Frame moves into the grayscale latch as the buffer drains
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         channel_gray_value_o <= `LPSD_GS_LATCH_RESET;
         channel_current_step_o <= `LPSD_DC_LATCH_RESET;
         gray_serial_out_o <= 1'b0;
         dotcorr_serial_out_o <= 1'b0;
         gray_latch_ready_o <= 1'b0;
      end else begin
         if (buf_out_valid && latch_accept_i) begin
            channel_gray_value_o <= buf_out_data;
         end
         if (dc_latch_rise) begin
            channel_current_step_o <= dc_shift_data;
         end
         gray_serial_out_o <= gray_sout;
         dotcorr_serial_out_o <= dc_sout;
         gray_latch_ready_o <= buf_in_ready;
      end
   end

   // ----------------------------------------------------------------
   // Blank synchroniser
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         blank_m_r <= 1'b1;
         blank_s_r <= 1'b1;
      end else begin
         blank_m_r <= blank_i;
         blank_s_r <= blank_m_r;
      end
   end

   // ----------------------------------------------------------------
   // Grayscale counter
   // ----------------------------------------------------------------
   // Counts shift clock rises, stops after the last step
   always @* begin
      gray_cnt_nxt = gray_cnt_r;
      if (blank_s_r) begin
         gray_cnt_nxt = `LPSD_CNT_RESET;
      end else if (gray_clk_rise && (gray_cnt_r != CNT_LAST)) begin
         gray_cnt_nxt = gray_cnt_r + 1'b1;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         gray_cnt_r <= `LPSD_CNT_RESET;
      end else begin
         gray_cnt_r <= gray_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Per-channel compare
   // ----------------------------------------------------------------
   // Channel is on while the count is below its value
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_cmp
         assign compare_on[ch] = ({1'b0, channel_gray_value_o[ch*GS_BITS +: GS_BITS]} >
                                  gray_cnt_r);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Group stagger delay line
   // ----------------------------------------------------------------
   // Later groups switch a few cycles after earlier ones to spread inrush;
   // blank travels alongside so it is never outrun by a stale compare
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         blank_dly_r <= {DLY_BITS{1'b1}};
         for (k = 0; k < DLY_BITS; k = k + 1) begin
            compare_dly_r[k] <= {CHANNELS{1'b0}};
         end
      end else begin
         blank_dly_r <= {blank_dly_r[DLY_BITS-2:0], blank_s_r};
         compare_dly_r[0] <= compare_on;
         for (k = 1; k < DLY_BITS; k = k + 1) begin
            compare_dly_r[k] <= compare_dly_r[k-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // Output gating
   // ----------------------------------------------------------------
   // Blank forces off at once; enabling waits for each group's tap
   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_gate
         assign channel_on_nxt[gi] = blank_s_r ? 1'b0 :
            blank_dly_r[(gi / GROUP_SIZE) * GROUP_DELAY] ? 1'b0 :
            compare_dly_r[(gi / GROUP_SIZE) * GROUP_DELAY][gi];
      end
   endgenerate

   // Registered channel outputs
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         channel_on_o <= {CHANNELS{1'b0}};
      end else begin
         channel_on_o <= channel_on_nxt;
      end
   end

endmodule

// file: tb/lpsd_core_assertions.sv
// Checker for the driver core: serial ports, latches, blanking and PWM.
// Assumes serial clocks far slower than ref_clk_i; sees top ports only.
`timescale 1ns/10ps
module lpsd_core_chk #(
   parameter CHANNELS = 16,
   parameter GS_BITS = 12,
   parameter DC_BITS = 7
) (
   input logic ref_clk_i,
   input logic rstn_i,
   input logic gray_serial_in_i,
   input logic gray_shift_clock_i,
   input logic gray_latch_strobe_i,
   input logic gray_serial_out_o,
   input logic dotcorr_serial_in_i,
   input logic dotcorr_shift_clock_i,
   input logic dotcorr_latch_strobe_i,
   input logic dotcorr_serial_out_o,
   input logic blank_i,
   input logic latch_accept_i,
   input logic gray_latch_ready_o,
   input logic [CHANNELS-1:0] channel_on_o,
   input logic [CHANNELS*GS_BITS-1:0] channel_gray_value_o,
   input logic [CHANNELS*DC_BITS-1:0] channel_current_step_o
);
   localparam GW = CHANNELS*GS_BITS;
   localparam DW = CHANNELS*DC_BITS;
   logic [GW-1:0] gsr_r;
   logic [DW-1:0] dsr_r;
   logic [12:0] cnt_r;
   logic [4:0] quiet_r;
   logic [CHANNELS-1:0] on_exp;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // ----
   // Shadow registers and settle timer
   // ----
   always @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         gsr_r <= '0;
         dsr_r <= '0;
         cnt_r <= 13'h0000;
         quiet_r <= 5'h00;
      end else begin
         if ($rose(gray_shift_clock_i)) gsr_r <= {gsr_r[GW-2:0], gray_serial_in_i};
         if ($rose(dotcorr_shift_clock_i)) dsr_r <= {dsr_r[DW-2:0], dotcorr_serial_in_i};
         if (blank_i) cnt_r <= 13'h0000;
         else if ($rose(gray_shift_clock_i) && cnt_r != 13'h1000) cnt_r <= cnt_r + 13'h0001;
         if (blank_i || $rose(gray_shift_clock_i) || $changed(channel_gray_value_o))
            quiet_r <= 5'h00;
         else if (quiet_r != 5'h1F) quiet_r <= quiet_r + 5'h01;
      end
   end
   // Expected channel enables from latch and count
   always @* begin
      for (int n = 0; n < CHANNELS; n++) on_exp[n] = channel_gray_value_o[n*GS_BITS +: GS_BITS] > cnt_r;
   end
   property p_blank_off;
      blank_i [*6] |-> channel_on_o == '0;
   endproperty
   a_blank_off: assert property (p_blank_off) else $error("outputs on while blanked");
   property p_gray_casc;
      $rose(gray_shift_clock_i) |-> ##6 gray_serial_out_o == gsr_r[GW-1];
   endproperty
   a_gray_casc: assert property (p_gray_casc) else $error("gray cascade bit wrong");
   property p_dot_casc;
      $rose(dotcorr_shift_clock_i) |-> ##6 dotcorr_serial_out_o == dsr_r[DW-1];
   endproperty
   a_dot_casc: assert property (p_dot_casc) else $error("dot cascade bit wrong");
   property p_gray_latch;
      ($rose(gray_latch_strobe_i) && latch_accept_i) ##1 latch_accept_i [*8]
         |-> channel_gray_value_o == gsr_r;
   endproperty
   a_gray_latch: assert property (p_gray_latch) else $error("gray latch wrong");
   property p_dot_latch;
      $rose(dotcorr_latch_strobe_i) |-> ##6 channel_current_step_o == dsr_r;
   endproperty
   a_dot_latch: assert property (p_dot_latch) else $error("dot latch wrong");
   property p_pwm;
      quiet_r == 5'h14 |-> channel_on_o == on_exp;
   endproperty
   a_pwm: assert property (p_pwm) else $error("channel enables wrong");
   property p_hold;
      !$past(latch_accept_i) |-> $stable(channel_gray_value_o);
   endproperty
   a_hold: assert property (p_hold) else $error("latch moved while stalled");
   property p_gray_quiet;
      !gray_shift_clock_i [*8] |-> $stable(gray_serial_out_o);
   endproperty
   a_gray_quiet: assert property (p_gray_quiet) else $error("cascade moved idle");
endmodule

bind lpsd_core lpsd_core_chk #(.CHANNELS(CHANNELS), .GS_BITS(GS_BITS), .DC_BITS(DC_BITS)) u_chk (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .gray_serial_in_i(gray_serial_in_i),
   .gray_shift_clock_i(gray_shift_clock_i), .gray_latch_strobe_i(gray_latch_strobe_i),
   .gray_serial_out_o(gray_serial_out_o), .dotcorr_serial_in_i(dotcorr_serial_in_i),
   .dotcorr_shift_clock_i(dotcorr_shift_clock_i),
   .dotcorr_latch_strobe_i(dotcorr_latch_strobe_i),
   .dotcorr_serial_out_o(dotcorr_serial_out_o), .blank_i(blank_i),
   .latch_accept_i(latch_accept_i), .gray_latch_ready_o(gray_latch_ready_o),
   .channel_on_o(channel_on_o), .channel_gray_value_o(channel_gray_value_o),
   .channel_current_step_o(channel_current_step_o)
);

// file: tb/lpsd_host_model.sv
// Host model driving one serial port of the driver core.
// Assumes callers run one task at a time; 64 ns shift clock.
`timescale 1ns/10ps
module lpsd_host_model #(
   parameter W = 192
) (
   output logic sclk_o,
   output logic sdin_o,
   output logic slat_o
);
   initial begin
      sclk_o = 1'b0;
      sdin_o = 1'b0;
      slat_o = 1'b0;
   end
   // Shift n bits, MSB first; clock rests low between frames
   task automatic send(input logic [W-1:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         sdin_o = v[i];
         #32 sclk_o = 1'b1;
         #16 sdin_o = ~v[i]; // Data past hold is not kept
         #16 sclk_o = 1'b0;
      end
   endtask
   // Latch pulse, issued after the frame
   task automatic latch;
      #32 slat_o = 1'b1;
      #64 slat_o = 1'b0;
      #32;
   endtask
endmodule

// file: tb/testbench.sv
// Testbench for the driver core: frames, cascade, PWM, blanking, buffer.
// Assumes two host models on the serial ports and the bound checker.
`timescale 1ns/10ps
module testbench;
   logic ref_clk_i = 0, rstn_i = 0, blank_i = 1, latch_accept_i = 1;
   logic gsin, gsclk, gslat, dsin, dsclk, dslat, gsout, dsout, gready;
   logic [15:0] on;
   logic [191:0] gval, prev = '0, fa, fb, fc;
   logic [111:0] dval, fd;
   logic [191:0] q[$];
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   lpsd_host_model #(.W(192)) u_gray_host (.sclk_o(gsclk), .sdin_o(gsin), .slat_o(gslat));
   lpsd_host_model #(.W(112)) u_dot_host (.sclk_o(dsclk), .sdin_o(dsin), .slat_o(dslat));
   lpsd_core u_lpsd_core (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .gray_serial_in_i(gsin),
      .gray_shift_clock_i(gsclk), .gray_latch_strobe_i(gslat), .gray_serial_out_o(gsout),
      .dotcorr_serial_in_i(dsin), .dotcorr_shift_clock_i(dsclk),
      .dotcorr_latch_strobe_i(dslat), .dotcorr_serial_out_o(dsout), .blank_i(blank_i),
      .latch_accept_i(latch_accept_i), .gray_latch_ready_o(gready), .channel_on_o(on),
      .channel_gray_value_o(gval), .channel_current_step_o(dval));
   task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   function automatic logic [15:0] exp_on(input logic [191:0] f, input int c);
      for (int n = 0; n < 16; n++) exp_on[n] = f[12*n +: 12] > c;
   endfunction
   function automatic logic [191:0] rnd_frame(input int m);
      for (int n = 0; n < 16; n++) rnd_frame[12*n +: 12] = 12'($urandom % m);
   endfunction
   // Timeout and latch watcher against queued frames
   always @(negedge ref_clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         close_out;
      end
   end
   always @(negedge ref_clk_i) begin
      if (rstn_i && gval !== prev) chk(gval, q.size() ? q.pop_front() : ~gval);
      prev <= gval;
   end
   initial begin
      void'($urandom(32'h06AD));
      tick(16);
      rstn_i = 1;
      tick(4);
      chk({on, dval}, '0);
      fa = rnd_frame(8);
      fa[11:0] = 12'h004;
      u_gray_host.send(fa, 192);
      tick(8);
      chk(gsout, fa[191]);
      q.push_back(fa);
      u_gray_host.latch();
      for (int n = 0; n < 16; n++) fd[7*n +: 7] = 7'($urandom);
      u_dot_host.send(fd, 112);
      tick(8);
      chk(dsout, fd[111]);
      u_dot_host.latch();
      tick(8);
      chk(dval, fd);
      blank_i = 0;
      tick(24);
      chk(on, exp_on(fa, 0));
      u_gray_host.send(192'h5, 4);
      tick(24);
      chk(on, exp_on(fa, 4));
      blank_i = 1;
      tick(6);
      chk(on, 16'h0000);
      blank_i = 0;
      tick(24);
      chk(on, exp_on(fa, 0));
      blank_i = 1;
      // Fill the buffer while stalled, then overflow it
      latch_accept_i = 0;
      fb = rnd_frame(4096);
      fc = rnd_frame(4096);
      u_gray_host.send(fb, 192);
      q.push_back(fb);
      u_gray_host.latch();
      u_gray_host.send(fc, 192);
      q.push_back(fc);
      u_gray_host.latch();
      tick(4);
      chk(gready, 1'b0);
      u_gray_host.send(192'hA5, 8);
      u_gray_host.latch();
      tick(4);
      latch_accept_i = 1;
      tick(12);
      chk(q.size(), 0);
      chk(gready, 1'b1);
      close_out;
   end
endmodule
